//--- rtl/pmc_ctrl.sv
/*
 * Port operating mode change controller with an APB register slave.
 * Runs remove, device number update, add and port action in order,
 * and couples resets and ASPM states within each partition.
 * Assumes core inputs are synchronous to pclk and software quiesces
 * the port and waits for completion between changes.
 */
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - A change inside one partition is a full removal then re-addition.
// - A device number change alone is removal, number update, then addition.
// - Set started flag, remove, add, apply action, then set done flag.
// - A partition losing its upstream port keeps working without one.
// - Removing the hot-reset-driving upstream port ends that partition hot reset.
// - Removing a downstream port leaves hot reset running on the others.
// - Removing an upstream port with secondary reset set ends partition bus reset.
// - Removing a downstream port leaves upstream secondary bus reset on others.
// - A removed downstream port's own secondary reset leaves the partition alone.
// - Removing a port invalidates all partition routes that target it.
// - Downstream receiver L0s exit starts L0s exit on upstream transmitter.
// - A removed downstream port no longer drives upstream L0s state.
// - Upstream receiver L0s exit starts L0s exit on all downstream transmitters.
// - A removed upstream port no longer drives downstream L0s state.
// - Upstream port enters L1 only when all downstream members are in L1.
// - A removed downstream port is left out of the L1 entry condition.
// - Removing an upstream port leaves downstream L1 state unchanged.
// - The action field selects reset or no action for the port.
module pmc_ctrl
	import pmc_pkg::*;
(
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic                          pready,
	output logic [31:0]                   prdata,
	output logic                          pslverr,
	// Switch core
	input  wire pmc_port_in_t [NPORT-1:0] port_in,
	output pmc_port_out_t [NPORT-1:0]     port_out,
	output logic [NPORT-1:0]              route_valid,
	output logic [NPORT-1:0]              port_reset,
	output logic                          busy
);

	// Sequencer and membership state
	pmc_state_t                 state_q, state_d;
	pmc_req_t                   req_q, req_d;
	logic [NPORT-1:0]           member_q, member_d;
	logic [NPORT-1:0]           up_q, up_d;
	logic [NPORT-1:0][PART_W-1:0] part_q, part_d;
	logic [NPORT-1:0][DEVN_W-1:0] devn_q, devn_d;
	logic [NPORT-1:0]           route_q, route_d;
	logic [NPORT-1:0]           started_q, started_d;
	logic [NPORT-1:0]           done_q, done_d;
	logic [NPORT-1:0]           preset_q, preset_d;

	// Bus side state
	logic [31:0]                rdata_q, rdata_d;

	// Coupling results
	pmc_port_out_t [NPORT-1:0]  couple_out;
	pmc_port_out_t [NPORT-1:0]  pout_q;
	logic [NPART-1:0]           part_hot;
	logic [NPART-1:0]           part_sbr;
	logic [NPART-1:0]           part_has_us;
	logic [NPART-1:0]           part_l1;

	// Bus strobes
	logic                       setup;
	logic                       wr;
	logic                       go_req;
	logic                       go_busy;
	pmc_req_t                   new_req;

	// Address decode, used by the error logic only
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_MAP)
			|| (a == ADDR_PART) || (a == ADDR_DEVN) || (a == ADDR_PWR);
	endfunction

	// Fields of a control write
	function automatic pmc_req_t decode_req(input logic [31:0] w);
		pmc_req_t r;
		r.port   = w[CTRL_PORT_LSB +: PORT_W];
		r.part   = w[CTRL_PART_LSB +: PART_W];
		r.up     = w[CTRL_UP_BIT];
		r.attach = w[CTRL_ATT_BIT];
		r.devnum = w[CTRL_DEVN_LSB +: DEVN_W];
		r.action = pmc_action_t'(w[CTRL_ACT_LSB +: 2]);
		return r;
	endfunction

	// Partition coupling of resets and power states
	pmc_couple u_couple (
		.member      (member_q),
		.upstream    (up_q),
		.part        (part_q),
		.port_in     (port_in),
		.port_out    (couple_out),
		.part_hot    (part_hot),
		.part_sbr    (part_sbr),
		.part_has_us (part_has_us),
		.part_l1     (part_l1)
	);

	// APB phase strobes
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pwrite;
	assign new_req = decode_req(pwdata);
	assign go_req  = wr & (paddr == ADDR_CTRL) & pwdata[CTRL_GO_BIT];
	assign go_busy = go_req & (state_q != PMC_ST_IDLE);

	// Zero wait state answer
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (~is_mapped(paddr) | go_busy);
	assign prdata  = rdata_q;

	// Outputs from flip-flops, busy decoded from state_q
	assign port_out    = pout_q;
	assign route_valid = route_q;
	assign port_reset  = preset_q;
	assign busy        = (state_q != PMC_ST_IDLE);

	// Read data captured in the setup phase
	always_comb begin
		rdata_d = rdata_q;
		if (setup) begin
			rdata_d = '0;
			case (paddr)
				ADDR_CTRL: begin
					rdata_d[CTRL_PORT_LSB +: PORT_W] = req_q.port;
					rdata_d[CTRL_PART_LSB +: PART_W] = req_q.part;
					rdata_d[CTRL_UP_BIT]             = req_q.up;
					rdata_d[CTRL_ATT_BIT]            = req_q.attach;
					rdata_d[CTRL_DEVN_LSB +: DEVN_W] = req_q.devnum;
					rdata_d[CTRL_ACT_LSB +: 2]       = req_q.action;
				end
				ADDR_STAT: begin
					rdata_d[STAT_START_LSB +: NPORT] = started_q;
					rdata_d[STAT_DONE_LSB +: NPORT]  = done_q;
					rdata_d[STAT_BUSY_BIT]           = busy;
				end
				ADDR_MAP: begin
					rdata_d[0 +: NPORT]             = member_q;
					rdata_d[MAP_UP_LSB +: NPORT]    = up_q;
					rdata_d[MAP_ROUTE_LSB +: NPORT] = route_q;
				end
				ADDR_PART: begin
					rdata_d[0 +: NPORT*PART_W] = part_q;
				end
				ADDR_DEVN: begin
					rdata_d = devn_q;
				end
				ADDR_PWR: begin
					rdata_d[PWR_HOT_LSB +: NPART] = part_hot;
					rdata_d[PWR_SBR_LSB +: NPART] = part_sbr;
					rdata_d[PWR_US_LSB +: NPART]  = part_has_us;
					rdata_d[PWR_L1_LSB +: NPART]  = part_l1;
				end
				default: begin
					rdata_d = RST_RDATA;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= RST_RDATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Mode change sequencer, one step per cycle
	always_comb begin
		state_d   = state_q;
		req_d     = req_q;
		member_d  = member_q;
		up_d      = up_q;
		part_d    = part_q;
		devn_d    = devn_q;
		route_d   = route_q;
		started_d = started_q;
		done_d    = done_q;
		preset_d  = '0;
		// Software clears flags first so a same-cycle set wins
		if (wr && paddr == ADDR_STAT) begin
			started_d = started_d & ~pwdata[STAT_START_LSB +: NPORT];
			done_d    = done_d & ~pwdata[STAT_DONE_LSB +: NPORT];
		end
		case (state_q)
			PMC_ST_IDLE: begin
				if (go_req) begin
					req_d                  = new_req;
					started_d[new_req.port] = 1'b1;
					done_d[new_req.port]    = 1'b0;
					state_d                = PMC_ST_REMOVE;
				end
			end
			PMC_ST_REMOVE: begin
				// Leaving the partition drops routes and all coupling
				member_d[req_q.port] = 1'b0;
				up_d[req_q.port]     = 1'b0;
				route_d[req_q.port]  = 1'b0;
				state_d              = PMC_ST_DEVN;
			end
			PMC_ST_DEVN: begin
				devn_d[req_q.port] = req_q.devnum;
				state_d            = PMC_ST_ADD;
			end
			PMC_ST_ADD: begin
				if (req_q.attach) begin
					member_d[req_q.port] = 1'b1;
					up_d[req_q.port]     = req_q.up;
					part_d[req_q.port]   = req_q.part;
					route_d[req_q.port]  = 1'b1;
				end
				state_d = PMC_ST_ACTION;
			end
			PMC_ST_ACTION: begin
				// Unknown codes behave as no action
				if (req_q.action == PMC_ACT_RESET) begin
					preset_d[req_q.port] = 1'b1;
				end
				state_d = PMC_ST_DONE;
			end
			PMC_ST_DONE: begin
				done_d[req_q.port] = 1'b1;
				state_d            = PMC_ST_IDLE;
			end
			default: begin
				state_d = PMC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= PMC_ST_IDLE;
			req_q     <= '0;
			member_q  <= RST_MEMBER;
			up_q      <= RST_MEMBER;
			part_q    <= '0;
			devn_q    <= '0;
			route_q   <= RST_MEMBER;
			started_q <= RST_FLAGS;
			done_q    <= RST_FLAGS;
			preset_q  <= RST_FLAGS;
		end else begin
			state_q   <= state_d;
			req_q     <= req_d;
			member_q  <= member_d;
			up_q      <= up_d;
			part_q    <= part_d;
			devn_q    <= devn_d;
			route_q   <= route_d;
			started_q <= started_d;
			done_q    <= done_d;
			preset_q  <= preset_d;
		end
	end

	// Registered coupling effects towards the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pout_q <= '0;
		end else begin
			pout_q <= couple_out;
		end
	end

endmodule // pmc_ctrl

`default_nettype wire

//--- rtl/pmc_pkg.sv
/*
 * Shared constants and types of the port mode change controller:
 * register offsets, field positions, reset values, states and carriers.
 * Assumes a switch of eight ports grouped into four partitions.
 */
package pmc_pkg;

	// Switch geometry
	localparam int NPORT  = 8;
	localparam int NPART  = 4;
	localparam int PORT_W = 3;
	localparam int PART_W = 2;
	localparam int DEVN_W = 4;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_MAP  = 8'h08;
	localparam logic [7:0] ADDR_PART = 8'h0c;
	localparam logic [7:0] ADDR_DEVN = 8'h10;
	localparam logic [7:0] ADDR_PWR  = 8'h14;

	// Control register fields
	localparam int CTRL_PORT_LSB = 0;
	localparam int CTRL_PART_LSB = 4;
	localparam int CTRL_UP_BIT   = 8;
	localparam int CTRL_ATT_BIT  = 9;
	localparam int CTRL_DEVN_LSB = 12;
	localparam int CTRL_ACT_LSB  = 16;
	localparam int CTRL_GO_BIT   = 31;

	// Status register fields
	localparam int STAT_START_LSB = 0;
	localparam int STAT_DONE_LSB  = 8;
	localparam int STAT_BUSY_BIT  = 16;

	// Map and power register fields
	localparam int MAP_UP_LSB    = 8;
	localparam int MAP_ROUTE_LSB = 16;
	localparam int PWR_HOT_LSB   = 0;
	localparam int PWR_SBR_LSB   = 4;
	localparam int PWR_US_LSB    = 8;
	localparam int PWR_L1_LSB    = 16;

	// Reset values
	localparam logic [NPORT-1:0] RST_MEMBER = 8'h00;
	localparam logic [NPORT-1:0] RST_FLAGS  = 8'h00;
	localparam logic [31:0]      RST_RDATA  = 32'h0000_0000;

	// Action applied to the port itself
	typedef enum logic [1:0] {
		PMC_ACT_NONE  = 2'b00,
		PMC_ACT_RESET = 2'b01
	} pmc_action_t;

	// Sequencer steps
	typedef enum logic [2:0] {
		PMC_ST_IDLE   = 3'b000,
		PMC_ST_REMOVE = 3'b001,
		PMC_ST_DEVN   = 3'b010,
		PMC_ST_ADD    = 3'b011,
		PMC_ST_ACTION = 3'b100,
		PMC_ST_DONE   = 3'b101
	} pmc_state_t;

	// One mode change request
	typedef struct packed {
		logic [PORT_W-1:0] port;
		logic [PART_W-1:0] part;
		logic              up;
		logic              attach;
		logic [DEVN_W-1:0] devnum;
		pmc_action_t       action;
	} pmc_req_t;

	// Per port state from the switch core
	typedef struct packed {
		logic hot_reset;
		logic secondary_reset_bit;
		logic rx_l0s_exit;
		logic in_l1;
	} pmc_port_in_t;

	// Per port effects towards the switch core
	typedef struct packed {
		logic hr_active;
		logic sbr_active;
		logic dsp_sbr;
		logic tx_l0s_exit;
		logic l1_ok;
	} pmc_port_out_t;

endpackage

//--- rtl/pmc_couple.sv
/*
 * Partition coupling of resets and link power states, purely combinational.
 * Assumes membership inputs come from the controller's own flip-flops.
 */
`timescale 1ns/1ns
`default_nettype none

module pmc_couple
	import pmc_pkg::*;
(
	// Membership
	input  wire logic [NPORT-1:0]             member,
	input  wire logic [NPORT-1:0]             upstream,
	input  wire logic [NPORT-1:0][PART_W-1:0] part,
	// Core state
	input  wire pmc_port_in_t [NPORT-1:0]     port_in,
	// Effects
	output pmc_port_out_t [NPORT-1:0]         port_out,
	output logic [NPART-1:0]                  part_hot,
	output logic [NPART-1:0]                  part_sbr,
	output logic [NPART-1:0]                  part_has_us,
	output logic [NPART-1:0]                  part_l1
);

	logic [NPART-1:0] us_rx_exit;
	logic [NPART-1:0] ds_rx_exit;

	// Per partition reductions over current members only
	always_comb begin
		part_hot    = '0;
		part_sbr    = '0;
		part_has_us = '0;
		us_rx_exit  = '0;
		ds_rx_exit  = '0;
		part_l1     = '1;
		for (int i = 0; i < NPORT; i++) begin
			for (int p = 0; p < NPART; p++) begin
				if (member[i] && part[i] == PART_W'(p)) begin
					if (upstream[i]) begin
						part_has_us[p] = 1'b1;
						part_hot[p]    = part_hot[p] | port_in[i].hot_reset;
						part_sbr[p]    = part_sbr[p] | port_in[i].secondary_reset_bit;
						us_rx_exit[p]  = us_rx_exit[p] | port_in[i].rx_l0s_exit;
					end else begin
						ds_rx_exit[p] = ds_rx_exit[p] | port_in[i].rx_l0s_exit;
						part_l1[p]    = part_l1[p] & port_in[i].in_l1;
					end
				end
			end
		end
	end

	// Per port effects
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_port
			logic is_us;
			logic is_ds;
			assign is_us = member[g] & upstream[g];
			assign is_ds = member[g] & ~upstream[g];
			assign port_out[g].hr_active   = is_ds & part_hot[part[g]];
			assign port_out[g].sbr_active  = is_ds & part_sbr[part[g]];
			assign port_out[g].dsp_sbr     = is_ds & port_in[g].secondary_reset_bit;
			assign port_out[g].tx_l0s_exit = (is_us & ds_rx_exit[part[g]])
				| (is_ds & us_rx_exit[part[g]]);
			assign port_out[g].l1_ok       = is_us & part_l1[part[g]];
		end
	endgenerate

endmodule // pmc_couple

`default_nettype wire

//--- testbench/pmc_core_model.sv
/* Switch core stand-in driving per-port reset and link power levels.
   Assumes the bench sets the wanted level of each port. */
`timescale 1ns/1ns
`default_nettype none
module pmc_core_model
	import pmc_pkg::*;
(
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// Wanted levels
	input  wire logic [NPORT-1:0]    hot,
	input  wire logic [NPORT-1:0]    sr,
	input  wire logic [NPORT-1:0]    l0s,
	input  wire logic [NPORT-1:0]    l1,
	// Core state
	output pmc_port_in_t [NPORT-1:0] port_in
);
	// Levels only, no packet traffic on any port
	always_ff @(posedge pclk or negedge presetn) begin
		for (int i = 0; i < NPORT; i++) begin
			if (!presetn)
				port_in[i] <= '0;
			else
				port_in[i] <= {hot[i], sr[i], l0s[i], l1[i]};
		end
	end
endmodule // pmc_core_model
`default_nettype wire

//--- testbench/pmc_ctrl_asserts.sv
/* Checker of the mode change controller ports.
   Assumes binding to pmc_ctrl, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module pmc_ctrl_asserts
	import pmc_pkg::*;
(
	// Clock, reset, bus
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	input  wire logic                     pslverr,
	// Core side
	input  wire pmc_port_in_t [NPORT-1:0] port_in,
	input  wire pmc_port_out_t [NPORT-1:0] port_out,
	input  wire logic [NPORT-1:0]         route_valid,
	input  wire logic [NPORT-1:0]         port_reset,
	input  wire logic                     busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic             go;
	logic [NPORT-1:0] rx, hr, tx, sb, ds, sbr, hrs;
	// Gather per-port bits
	always_comb begin
		go = psel & penable & pwrite & (paddr == ADDR_CTRL) & pwdata[CTRL_GO_BIT];
		for (int i = 0; i < NPORT; i++) begin
			rx[i] = port_in[i].rx_l0s_exit;
			hrs[i] = port_in[i].hot_reset;
			sbr[i] = port_in[i].secondary_reset_bit;
			hr[i] = port_out[i].hr_active;
			tx[i] = port_out[i].tx_l0s_exit;
			sb[i] = port_out[i].sbr_active;
			ds[i] = port_out[i].dsp_sbr;
		end
	end
	sequence s_go; go && !busy; endsequence
	sequence s_run; busy[*5] ##1 !busy; endsequence
	property p_seq; s_go |=> s_run; endproperty
	a_seq: assert property (p_seq) else $error("step count wrong");
	property p_refuse; go && busy |-> pslverr; endproperty
	a_refuse: assert property (p_refuse) else $error("overlap taken");
	property p_unmap; psel && penable && paddr > ADDR_PWR |-> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("no slverr");
	property p_pulse; |port_reset |-> $onehot(port_reset) && busy ##1 port_reset == '0; endproperty
	a_pulse: assert property (p_pulse) else $error("bad port reset");
	property p_route; !$stable(route_valid) |-> busy || $past(busy); endproperty
	a_route: assert property (p_route) else $error("route moved idle");
	property p_l0s; |tx |-> $past(|rx); endproperty
	a_l0s: assert property (p_l0s) else $error("l0s exit no cause");
	property p_hot; |hr |-> $past(|hrs); endproperty
	a_hot: assert property (p_hot) else $error("hot reset no cause");
	property p_sbr; |sb |-> $past(|sbr); endproperty
	a_sbr: assert property (p_sbr) else $error("bus reset no cause");
	property p_dsp; (ds & ~$past(sbr)) == '0; endproperty
	a_dsp: assert property (p_dsp) else $error("own reset spread");
endmodule // pmc_ctrl_asserts
bind pmc_ctrl pmc_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr),
	.port_in(port_in), .port_out(port_out), .route_valid(route_valid),
	.port_reset(port_reset), .busy(busy));
`default_nettype wire

//--- testbench/tb_top.sv
/* Self-checking bench of the mode change controller over APB.
   Assumes zero-wait APB and port_out two cycles behind the bench. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pmc_pkg::*;
	logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
	logic                      er_q, dr_q, lb;
	logic [7:0]                paddr;
	logic [31:0]               pwdata, prdata, rd_q;
	logic [NPORT-1:0]          hot, sr, l0s, l1, route_valid, port_reset, rs_q;
	pmc_port_in_t [NPORT-1:0]  port_in;
	pmc_port_out_t [NPORT-1:0] port_out;
	int                        errors, samples_checked;
	pmc_core_model u_core (.pclk(pclk), .presetn(presetn), .hot(hot), .sr(sr), .l0s(l0s),
		.l1(l1), .port_in(port_in));
	pmc_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .port_in(port_in), .port_out(port_out),
		.route_valid(route_valid), .port_reset(port_reset), .busy(busy));
	// Clock
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer, request held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_q = prdata;
		er_q = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(0, a, 0);
		chk(rd_q & m, exp);
	endtask
	// Poll until idle, then clear flags
	task automatic idle(input logic [2:0] p);
		do begin
			apb(0, ADDR_STAT, 0);
		end while (rd_q[STAT_BUSY_BIT] !== 1'b0);
		chk({rd_q[STAT_DONE_LSB+p], rd_q[STAT_START_LSB+p]}, 2'b11);
		apb(1, ADDR_STAT, 32'h0000_ffff);
	endtask
	// Mode change, watching route and port reset meanwhile
	task automatic mc(input logic [2:0] p, input logic [1:0] pt, input logic up, input logic at,
		input logic [3:0] dn, input pmc_action_t act);
		dr_q = 0;
		rs_q = '0;
		apb(1, ADDR_CTRL, {1'b1, 13'h0, act, dn, 2'h0, at, up, 2'h0, pt, 1'b0, p});
		fork
			idle(p);
			repeat (8) begin
				@(posedge pclk);
				rs_q = rs_q | port_reset;
				if (busy === 1'b1 && route_valid[p] === 1'b0)
					dr_q = 1;
			end
		join
		repeat (3) @(posedge pclk);
	endtask
	// Core levels, then settle
	task automatic lv(input logic [7:0] h, input logic [7:0] s, input logic [7:0] z,
		input logic [7:0] o);
		@(posedge pclk);
		hot <= h;
		sr <= s;
		l0s <= z;
		l1 <= o;
		repeat (3) @(posedge pclk);
	endtask
	task automatic close_out;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		#300000;
		errors++;
		close_out();
	end
	// Tests
	initial begin
		{psel, penable, pwrite, paddr, pwdata, hot, sr, l0s, l1} = '0;
		presetn = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		rdc(ADDR_MAP, 32'h0, '1);
		rdc(ADDR_STAT, 32'h0, '1);
		apb(0, 8'h40, 0);
		chk({31'h0, er_q}, 32'h1);
		chk(rd_q, 32'h0);
		$display("test 1 done");
		mc(0, 1, 1, 1, 0, PMC_ACT_NONE);
		mc(1, 1, 0, 1, 0, PMC_ACT_NONE);
		mc(2, 1, 0, 1, 0, PMC_ACT_RESET);
		chk(rs_q, 8'h04);
		rdc(ADDR_MAP, 32'h0007_0107, '1);
		apb(1, ADDR_CTRL, 32'h8000_0003);
		apb(1, ADDR_CTRL, 32'h8000_0003);
		chk(er_q, 1);
		idle(3);
		$display("test 2 done");
		lv(0, 0, 8'h01, 8'h02);
		chk({port_out[0].tx_l0s_exit, port_out[1].tx_l0s_exit, port_out[2].tx_l0s_exit}, 3'b011);
		chk(port_out[0].l1_ok, 0);
		lv(0, 0, 8'h02, 8'h06);
		chk({port_out[0].tx_l0s_exit, port_out[2].tx_l0s_exit, port_out[0].l1_ok}, 3'b101);
		$display("test 3 done");
		lv(8'h01, 8'h01, 8'h04, 8'h02);
		chk({port_out[0].tx_l0s_exit, port_out[0].l1_ok, port_out[2].hr_active}, 3'b101);
		mc(2, 0, 0, 0, 0, PMC_ACT_NONE);
		chk({port_out[1].hr_active, port_out[2].hr_active}, 2'b10);
		chk({port_out[1].sbr_active, port_out[2].sbr_active}, 2'b10);
		chk({port_out[0].tx_l0s_exit, port_out[0].l1_ok}, 2'b01);
		chk(route_valid, 8'h03);
		$display("test 4 done");
		lv(0, 8'h02, 0, 0);
		mc(1, 1, 0, 1, 4'h5, PMC_ACT_NONE);
		chk({dr_q, route_valid}, {1'b1, 8'h03});
		rdc(ADDR_DEVN, 32'h50, 32'hf0);
		rdc(ADDR_PWR, 32'h0, 32'h20);
		chk({port_out[1].dsp_sbr, port_out[1].sbr_active}, 2'b10);
		$display("test 5 done");
		lv(8'h01, 8'h01, 8'h01, 8'h02);
		rdc(ADDR_PWR, 32'h222, 32'h222);
		mc(2, 1, 0, 1, 0, PMC_ACT_NONE);
		lb = port_out[1].l1_ok;
		mc(0, 0, 0, 0, 0, PMC_ACT_NONE);
		chk({port_out[1].hr_active, port_out[1].sbr_active}, 2'b00);
		chk({port_out[1].tx_l0s_exit, port_out[1].l1_ok}, {1'b0, lb});
		rdc(ADDR_PWR, 32'h0, 32'h222);
		chk(route_valid, 8'h06);
		$display("test 6 done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
